/* hw/sltx_top.sv */
// Summary of operation
// R1: data is packed into octets, F octets form a frame, frames spread over L lanes.
// R2: N-bit samples ride as N-prime-bit fields, S per converter per frame, M converters.
// R3: one transport mode select value fixes lanes, octets per frame and K.
// R4: 8b/10b scrambles only with scramble enable; 64b/66b would always scramble.
// R5: scrambling acts on each octet before the 10-bit encoder.
// R6: the alignment sequence is never scrambled.
// R7: each octet becomes a DC-balanced 10-bit character tracking running disparity.
// R8: K lies between ceil(17/F) and min(256, floor(1024/F)), same at both ends.
// R9: SYSREF resets the local multiframe counter to a fixed phase.
// R10: multiframe clock equals line bit rate over 10 times F times K.
// R11: a continuous SYSREF runs at the multiframe rate or an integer division.
// R12: while SYNC is low every lane sends K28.5 continuously.
// R13: receiver pulls SYNC low, locks on four K28.5, releases at multiframe edge.
// R14: after SYNC rises, wait for the next multiframe edge before alignment sequence.
// R15: alignment sequence is four multiframes, each opens K28.0 and closes K28.3.
// R16: the second alignment multiframe carries the link configuration.
// R17: receiver buffers from first K28.0 and releases all lanes together.
// R18: unscrambled, a repeated frame-last octet becomes K28.7, or K28.3 at multiframe end.
// R19: unscrambled, receiver replaces alignment characters with the previous frame's last octet.
// R20: scrambled, frame-last 0xFC becomes K28.7, multiframe-last 0x7C becomes K28.3.
// R21: scrambled, receiver maps K28.7 back to 0xFC and K28.3 to 0x7C.
// R22: on misalignment receiver should pull SYNC low and SYSREF be reissued.
// R23: SYNC dropping during data returns the lanes to K28.5 until the handshake ends.
`timescale 1ns/1ps
`include "sltx_consts.svh"
module sltx_top import sltx_pkg::*; #(
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // converter samples, 16-bit fields, upper octet first
  input wire logic [15:0] sample_i,
  input wire logic sample_valid_i,
  output logic sample_ready_o,
  // configuration
  input wire logic [1:0] transport_mode_select_i,
  input wire logic scramble_enable_i,
  // link pins
  input wire logic sync_n_i,
  input wire logic sysref_i,
  // lane characters, lane 0 in the low ten bits, bit 9 sent first
  output logic [`SLTX_LANES*10-1:0] lane_char_o,
  // status
  output logic lmfc_o,
  output logic link_up_o
);

  //////////////////////////////////////////////////////////////////////////////
  localparam logic [5:0] C6 [32] = '{
    6'b100111, 6'b011101, 6'b101101, 6'b110001, 6'b110101, 6'b101001, 6'b011001, 6'b111000,
    6'b111001, 6'b100101, 6'b010101, 6'b110100, 6'b001101, 6'b101100, 6'b011100, 6'b010111,
    6'b011011, 6'b100011, 6'b010011, 6'b110010, 6'b001011, 6'b101010, 6'b011010, 6'b111010,
    6'b110011, 6'b100110, 6'b010110, 6'b110110, 6'b001110, 6'b101110, 6'b011110, 6'b101011
  };
  localparam logic [3:0] C4D [8] = '{
    4'b1011, 4'b1001, 4'b0101, 4'b1100, 4'b1101, 4'b1010, 4'b0110, 4'b1110
  };
  localparam logic [3:0] C4K [8] = '{
    4'b1011, 4'b0110, 4'b1010, 4'b1100, 4'b1101, 4'b0101, 4'b1001, 4'b0111
  };

  // returns {running disparity after, abcdei, fghj}; rd low means negative
  function automatic logic [10:0] enc8b10b(input logic [7:0] d, input logic k,
                                           input logic rd);
    logic [5:0] c6;
    logic [3:0] c4;
    logic rd6;
    logic alt7;
    c6 = k ? 6'b001111 : C6[d[4:0]];
    if (rd && (($countones(c6) != 3) || (!k && d[4:0] == 5'h07))) begin
      c6 = ~c6;
    end
    rd6 = ($countones(c6) != 3) ? ~rd : rd;
    // alternate x.7 avoids a run of five equal bits across the boundary
    alt7 = (!rd6 && (d[4:0] == 5'h11 || d[4:0] == 5'h12 || d[4:0] == 5'h14)) ||
           (rd6 && (d[4:0] == 5'h0b || d[4:0] == 5'h0d || d[4:0] == 5'h0e));
    c4 = k ? C4K[d[7:5]] : C4D[d[7:5]];
    if (!k && d[7:5] == 3'h7 && alt7) begin
      c4 = 4'b0111;
    end
    if (rd6 && (($countones(c4) != 2) || d[7:5] == 3'h3 || k)) begin
      c4 = ~c4;
    end
    enc8b10b = {(($countones(c4) != 2) ? ~rd6 : rd6), c6, c4};
  endfunction

  // self-synchronous 1 + x^14 + x^15, msb first
  function automatic logic [22:0] scr8(input logic [7:0] d, input logic [14:0] s);
    logic [14:0] st;
    logic [7:0] o;
    logic b;
    st = s;
    o = '0;
    for (int j = 7; j >= 0; j--) begin
      b = d[j] ^ st[14] ^ st[13];
      o[j] = b;
      st = {st[13:0], b};
    end
    scr8 = {st, o};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  sltx_stream_if #(.WIDTH(16)) smp_if ();

  sltx_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .in_data_i(sample_i),
    .in_valid_i(sample_valid_i),
    .in_ready_o(sample_ready_o),
    .out_if(smp_if.src)
  );

  //////////////////////////////////////////////////////////////////////////////
  sltx_st_t st_ff;
  sltx_st_t nxt_st;
  sltx_mode_t cfg;
  logic scr_on;
  logic sync_rise;
  logic sref_rise;
  logic at_first;
  logic at_flast;
  logic at_last;
  logic pop;
  logic [15:0] smp;
  logic [7:0] lane_in [`SLTX_LANES];
  logic [9:0] idx;
  logic [7:0] oct;
  logic [7:0] scr_d;
  logic [14:0] scr_s;
  logic k;
  logic [10:0] code;

  always_comb begin
    nxt_st = st_ff;
    oct = '0;
    k = 1'b0;
    scr_d = '0;
    scr_s = '0;
    code = '0;
    cfg = SLTX_MODES[transport_mode_select_i]; // see R3
    scr_on = scramble_enable_i | cfg.enc66; // see R4

    nxt_st.sync_m = sync_n_i;
    nxt_st.sync_s = st_ff.sync_m;
    nxt_st.sync_d = st_ff.sync_s;
    nxt_st.sref_m = sysref_i;
    nxt_st.sref_s = st_ff.sref_m;
    nxt_st.sref_d = st_ff.sref_s;
    sync_rise = st_ff.sync_s & ~st_ff.sync_d;
    sref_rise = st_ff.sref_s & ~st_ff.sref_d;

    // one character per clock per lane, so F*K clocks make one multiframe
    at_first = (st_ff.oct_cnt == '0) && (st_ff.frm_cnt == '0);
    at_flast = (st_ff.oct_cnt == 3'(cfg.f - 3'd1));
    at_last = at_flast && (st_ff.frm_cnt == 9'(cfg.k - 9'd1));
    if (sref_rise) begin // see R9
      nxt_st.oct_cnt = '0;
      nxt_st.frm_cnt = '0;
    end else if (at_flast) begin // see R10
      nxt_st.oct_cnt = '0;
      nxt_st.frm_cnt = at_last ? '0 : 9'(st_ff.frm_cnt + 9'd1);
    end else begin
      nxt_st.oct_cnt = 3'(st_ff.oct_cnt + 3'd1);
    end
    nxt_st.lmfc = at_first;

    case (st_ff.state)
      S_CGS: begin
        if (sync_rise) begin
          nxt_st.state = S_WAIT;
        end
      end
      S_WAIT: begin
        if (at_last) begin // see R14
          nxt_st.state = S_ILAS;
          nxt_st.ilas_mf = '0;
        end
      end
      S_ILAS: begin
        if (at_last) begin
          if (st_ff.ilas_mf == `SLTX_ILAS_MF_LAST) begin // see R15
            nxt_st.state = S_DATA;
            nxt_st.link_up = 1'b1;
            nxt_st.phase = 1'b0;
          end else begin
            nxt_st.ilas_mf = 2'(st_ff.ilas_mf + 2'd1);
          end
        end
      end
      S_DATA: begin
        nxt_st.phase = (cfg.lanes == 2'd1) ? ~st_ff.phase : 1'b0;
      end
      default: begin
        nxt_st.state = S_CGS;
      end
    endcase
    if (!st_ff.sync_s) begin // see R12 see R23
      nxt_st.state = S_CGS;
      nxt_st.link_up = 1'b0;
    end

    // transport: a 16-bit field is two octets; one lane takes two clocks for it
    pop = (st_ff.state == S_DATA) && ((cfg.lanes == 2'd2) || !st_ff.phase); // see R2
    smp = smp_if.valid ? smp_if.data : 16'h0000;
    if (pop) begin
      nxt_st.lo_hold = smp[7:0];
    end
    lane_in[0] = (cfg.lanes == 2'd1 && st_ff.phase) ? st_ff.lo_hold : smp[15:8]; // see R1
    lane_in[1] = smp[7:0];

    idx = 10'(10'(st_ff.frm_cnt) * 10'(cfg.f) + 10'(st_ff.oct_cnt));
    for (int i = 0; i < `SLTX_LANES; i++) begin
      k = 1'b1;
      oct = `SLTX_K28_5;
      if (i >= int'(cfg.lanes)) begin
        oct = `SLTX_K28_5;
      end else if (st_ff.state == S_ILAS) begin
        // never scrambled: the scrambler state is left alone here, see R6
        k = 1'b0;
        oct = idx[7:0];
        if (idx == '0) begin
          k = 1'b1;
          oct = `SLTX_K28_0; // see R15
        end else if (at_last) begin
          k = 1'b1;
          oct = `SLTX_K28_3;
        end else if (st_ff.ilas_mf == 2'd1 && idx == 10'd1) begin
          k = 1'b1;
          oct = `SLTX_K28_4;
        end else if (st_ff.ilas_mf == 2'd1 && idx < 10'd8) begin // see R16
          case (idx[2:0])
            3'd2: oct = 8'(cfg.lanes - 2'd1);
            3'd3: oct = 8'(cfg.f - 3'd1);
            3'd4: oct = 8'(cfg.k - 9'd1);
            3'd5: oct = {6'h00, transport_mode_select_i};
            3'd6: oct = {scr_on, 6'h00, 1'(i)};
            default: oct = 8'h00;
          endcase
        end
      end else if (st_ff.state == S_DATA) begin
        k = 1'b0;
        oct = lane_in[i];
        if (scr_on) begin // see R5
          {scr_s, scr_d} = scr8(lane_in[i], st_ff.lane[i].scramble_enable);
          nxt_st.lane[i].scramble_enable = scr_s;
          oct = scr_d;
        end
        if (at_flast) begin
          nxt_st.lane[i].prev_last = oct;
          if (scr_on) begin // see R20
            k = (oct == `SLTX_K28_7) || (at_last && oct == `SLTX_K28_3);
          end else if (oct == st_ff.lane[i].prev_last) begin // see R18
            k = 1'b1;
            oct = at_last ? `SLTX_K28_3 : `SLTX_K28_7;
          end
        end
      end
      code = enc8b10b(oct, k, st_ff.lane[i].rd); // see R7
      nxt_st.lane[i].rd = code[10];
      nxt_st.lane[i].chr = code[9:0];
      nxt_st.lane[i].oct = oct;
      nxt_st.lane[i].isk = k;
    end
  end

  assign smp_if.ready = pop;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.state <= S_CGS;
      for (int i = 0; i < `SLTX_LANES; i++) begin
        st_ff.lane[i].scramble_enable <= `SLTX_SCR_SEED;
      end
    end else begin
      st_ff <= nxt_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  for (genvar g = 0; g < `SLTX_LANES; g++) begin : g_out
    assign lane_char_o[g*10 +: 10] = st_ff.lane[g].chr;
  end
  assign lmfc_o = st_ff.lmfc;
  assign link_up_o = st_ff.link_up;

  //////////////////////////////////////////////////////////////////////////////
  property p_cgs_comma;
    @(posedge clk_sys_i) disable iff (rst_i)
      (st_ff.state == S_CGS) |=> (st_ff.lane[0].isk && st_ff.lane[0].oct == `SLTX_K28_5);
  endproperty
  a_cgs_comma: assert property (p_cgs_comma) else $error("no comma during sync"); // see R12

  property p_sync_drop;
    @(posedge clk_sys_i) disable iff (rst_i)
      (st_ff.link_up && !st_ff.sync_s) |=> (st_ff.state == S_CGS) ##1 (!st_ff.link_up)[*2];
  endproperty
  a_sync_drop: assert property (p_sync_drop) else $error("data kept after sync low"); // see R23

  property p_ilas_start;
    @(posedge clk_sys_i) disable iff (rst_i)
      (st_ff.state == S_ILAS && $past(st_ff.state) == S_WAIT)
        |-> (st_ff.oct_cnt == 3'd0 && st_ff.frm_cnt == 9'd0);
  endproperty
  a_ilas_start: assert property (p_ilas_start) else $error("ilas off multiframe edge"); // see R14

  property p_ilas_open;
    @(posedge clk_sys_i) disable iff (rst_i)
      (st_ff.state == S_ILAS && at_first && st_ff.sync_s)
        |=> (st_ff.lane[0].isk && st_ff.lane[0].oct == `SLTX_K28_0);
  endproperty
  a_ilas_open: assert property (p_ilas_open) else $error("multiframe not opened by K28.0"); // see R15

  property p_ilas_len;
    @(posedge clk_sys_i) disable iff (rst_i)
      $rose(st_ff.link_up) |-> ($past(st_ff.ilas_mf) == 2'd3 && $past(st_ff.state) == S_ILAS);
  endproperty
  a_ilas_len: assert property (p_ilas_len) else $error("ilas length wrong"); // see R15

  property p_ilas_plain;
    @(posedge clk_sys_i) disable iff (rst_i)
      (st_ff.state == S_ILAS) |=> $stable(st_ff.lane[0].scramble_enable);
  endproperty
  a_ilas_plain: assert property (p_ilas_plain) else $error("ilas was scrambled"); // see R6

  property p_scr_off;
    @(posedge clk_sys_i) disable iff (rst_i)
      (st_ff.state == S_DATA && !scr_on) |=> $stable(st_ff.lane[0].scramble_enable);
  endproperty
  a_scr_off: assert property (p_scr_off) else $error("scrambler ran while disabled"); // see R4

  property p_sysref;
    @(posedge clk_sys_i) disable iff (rst_i)
      sref_rise |=> (st_ff.oct_cnt == 3'd0 && st_ff.frm_cnt == 9'd0) ##1 st_ff.lmfc;
  endproperty
  a_sysref: assert property (p_sysref) else $error("sysref did not reset phase"); // see R9

  // a sysref edge may legally restart the multiframe early, so it drops the attempt
  property p_lmfc_gap;
    @(posedge clk_sys_i) disable iff (rst_i || sref_rise)
      st_ff.lmfc |=> (!st_ff.lmfc)[*8];
  endproperty
  a_lmfc_gap: assert property (p_lmfc_gap) else $error("multiframe clock too fast"); // see R10

  property p_k_range;
    @(posedge clk_sys_i) disable iff (rst_i)
      1'b1 |-> (int'(cfg.k) * int'(cfg.f) >= `SLTX_KF_MIN && int'(cfg.k) <= `SLTX_K_MAX &&
                int'(cfg.k) * int'(cfg.f) <= `SLTX_KF_MAX);
  endproperty
  a_k_range: assert property (p_k_range) else $error("K out of range"); // see R8
endmodule

/* hw/sltx_consts.svh */
`ifndef SLTX_CONSTS_SVH
`define SLTX_CONSTS_SVH

// lanes built into the output port
`define SLTX_LANES 2
// control characters, as the octet fed to the encoder with k set
`define SLTX_K28_0 8'h1c
`define SLTX_K28_3 8'h7c
`define SLTX_K28_4 8'h9c
`define SLTX_K28_5 8'hbc
`define SLTX_K28_7 8'hfc
// index of the last alignment multiframe, counted from zero
`define SLTX_ILAS_MF_LAST 2'h3
// bounds on frames per multiframe, the 17 and 1024 applying to F times K
`define SLTX_KF_MIN 17
`define SLTX_K_MAX 256
`define SLTX_KF_MAX 1024
// scrambler seed after reset
`define SLTX_SCR_SEED 15'h7fff

`endif

/* hw/sltx_pkg.sv */
package sltx_pkg;
  `include "sltx_consts.svh"

  typedef enum logic [3:0] {
    S_CGS  = 4'b0001,
    S_WAIT = 4'b0010,
    S_ILAS = 4'b0100,
    S_DATA = 4'b1000
  } sltx_state_t;

  typedef struct packed {
    logic [1:0] lanes;
    logic [2:0] f;
    logic [8:0] k;
    logic enc66;
  } sltx_mode_t;

  typedef struct packed {
    logic [14:0] scramble_enable;
    logic rd;
    logic [7:0] prev_last;
    logic [7:0] oct;
    logic isk;
    logic [9:0] chr;
  } sltx_lane_t;

  typedef struct packed {
    sltx_state_t state;
    logic sync_m;
    logic sync_s;
    logic sync_d;
    logic sref_m;
    logic sref_s;
    logic sref_d;
    logic [2:0] oct_cnt;
    logic [8:0] frm_cnt;
    logic [1:0] ilas_mf;
    logic phase;
    logic [7:0] lo_hold;
    logic lmfc;
    logic link_up;
    sltx_lane_t [`SLTX_LANES-1:0] lane;
  } sltx_st_t;

  // predefined transport modes: lanes, octets per frame, frames per multiframe
  localparam sltx_mode_t SLTX_MODES [4] = '{
    '{lanes: 2'd2, f: 3'd1, k: 9'd32, enc66: 1'b0},
    '{lanes: 2'd1, f: 3'd2, k: 9'd32, enc66: 1'b0},
    '{lanes: 2'd2, f: 3'd2, k: 9'd16, enc66: 1'b0},
    '{lanes: 2'd1, f: 3'd4, k: 9'd16, enc66: 1'b0}
  };
endpackage

/* hw/sltx_stream_if.sv */
`timescale 1ns/1ps
interface sltx_stream_if #(parameter int WIDTH = 16);
  logic [WIDTH-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

/* hw/sltx_fifo.sv */
`timescale 1ns/1ps
module sltx_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // fill side
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  // drain side
  sltx_stream_if.src out_if
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic in_ready;
  } sltx_fifo_st_t;

  sltx_fifo_st_t st_ff;
  sltx_fifo_st_t nxt_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  always_comb begin
    nxt_st = st_ff;
    push = in_valid_i & st_ff.in_ready;
    pop = out_if.ready & (st_ff.count != '0);
    if (push) begin
      nxt_st.wr_ptr = bump(st_ff.wr_ptr);
    end
    if (pop) begin
      nxt_st.rd_ptr = bump(st_ff.rd_ptr);
    end
    nxt_st.count = (AW+1)'(st_ff.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    // registered ready keeps the source from seeing a combinational path
    nxt_st.in_ready = (nxt_st.count < (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.in_ready <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[st_ff.wr_ptr] <= in_data_i;
    end
  end

  assign in_ready_o = st_ff.in_ready;
  assign out_if.data = mem[st_ff.rd_ptr];
  assign out_if.valid = (st_ff.count != '0);
endmodule

/* test/sltx_rx_model.sv */
`timescale 1ns/1ps
module sltx_rx_model (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // link from the transmitter
  input wire logic [19:0] lane_char_i,
  input wire logic lmfc_i,
  // bench asks for the link to be held up
  input wire logic link_req_i,
  // pins back to the transmitter
  output logic sync_n_o,
  output logic sysref_o
);
  logic [2:0] lock_cnt_ff;
  logic [3:0] sref_cnt_ff;
  logic comma;

  // comma in either disparity; the lane is watched only on lane 0
  assign comma = (lane_char_i[9:0] === 10'h0fa) || (lane_char_i[9:0] === 10'h305);

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      lock_cnt_ff <= 3'h0;
      sref_cnt_ff <= 4'h0;
      sync_n_o <= 1'b0;
      sysref_o <= 1'b0;
    end else begin
      // one pulse only; a free-running one would have to track the multiframe rate
      if (sref_cnt_ff != 4'hf) begin
        sref_cnt_ff <= sref_cnt_ff + 4'h1;
      end
      sysref_o <= (sref_cnt_ff == 4'h3);
      if (!link_req_i) begin
        sync_n_o <= 1'b0;
        lock_cnt_ff <= 3'h0;
      end else if (comma) begin
        if (lock_cnt_ff != 3'h4) begin
          lock_cnt_ff <= lock_cnt_ff + 3'h1;
        end
      end else if (!sync_n_o) begin
        lock_cnt_ff <= 3'h0;
      end
      // release only on a multiframe edge after four commas
      if (link_req_i && lock_cnt_ff == 3'h4 && lmfc_i) begin
        sync_n_o <= 1'b1;
      end
    end
  end
endmodule

/* test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import sltx_pkg::*;
  localparam logic [9:0] C_K28_5 = 10'h0fa;
  localparam logic [9:0] C_K28_0 = 10'h0f4;
  localparam logic [9:0] C_K28_3 = 10'h0f3;
  localparam logic [9:0] C_K28_7 = 10'h0f8;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] sample = 16'h0000;
  logic sample_valid = 1'b0;
  logic sample_ready;
  logic [1:0] mode = 2'h0;
  logic scramble_enable = 1'b0;
  logic sync_n;
  logic sysref;
  logic [19:0] lane_char;
  logic lmfc;
  logic link_up;
  logic link_req = 1'b0;
  logic alt = 1'b0;
  int failures = 0;
  int n_tests = 0;
  int fk = 32;

  always #2.5 clk_sys_i = ~clk_sys_i;

  sltx_top #(.FIFO_DEPTH(4)) i_sltx_top (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .sample_i(sample),
    .sample_valid_i(sample_valid), .sample_ready_o(sample_ready),
    .transport_mode_select_i(mode), .scramble_enable_i(scramble_enable), .sync_n_i(sync_n),
    .sysref_i(sysref), .lane_char_o(lane_char), .lmfc_o(lmfc), .link_up_o(link_up)
  );

  sltx_rx_model i_sltx_rx_model (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .lane_char_i(lane_char), .lmfc_i(lmfc),
    .link_req_i(link_req), .sync_n_o(sync_n), .sysref_o(sysref)
  );

  // alternating words, so no two successive frames end alike
  always @(posedge clk_sys_i) begin
    if (alt && sample_valid && sample_ready) begin
      sample <= ~sample;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic is_k(input logic [9:0] c, input logic [9:0] rdm);
    return (c === rdm) || (c === ~rdm);
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("Counts: %0d checks, %0d mismatches", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic do_reset(input logic [1:0] m, input logic s);
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    link_req <= 1'b0;
    mode <= m;
    scramble_enable <= s;
    sample_valid <= 1'b0;
    alt <= 1'b0;
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    fk = int'(SLTX_MODES[m].f) * int'(SLTX_MODES[m].k);
  endtask

  // handshake, then the four alignment multiframes
  task automatic bring_up();
    int t;
    t = 0;
    repeat (8) @(negedge clk_sys_i);
    check(is_k(lane_char[9:0], C_K28_5), 1);
    check(is_k(lane_char[19:10], C_K28_5), 1);
    check(link_up, 0);
    @(posedge clk_sys_i);
    link_req <= 1'b1;
    while (!is_k(lane_char[9:0], C_K28_0) && t < 4000) begin
      @(negedge clk_sys_i);
      t++;
    end
    check(t < 4000, 1);
    check(lmfc, 1);
    for (int m = 0; m < 4; m++) begin
      repeat (fk - 1) @(negedge clk_sys_i);
      check(lmfc, 0);
      check(is_k(lane_char[9:0], C_K28_3), 1);
      @(negedge clk_sys_i);
      check(lmfc, 1);
      if (m < 3) begin
        check(is_k(lane_char[9:0], C_K28_0), 1);
      end
    end
    t = 0;
    while (link_up !== 1'b1 && t < 4) begin
      @(negedge clk_sys_i);
      t++;
    end
    check(t < 4, 1);
  endtask

  // count lane 0 alignment characters over one multiframe
  task automatic count_align(output int n7, output int n3);
    n7 = 0;
    n3 = 0;
    repeat (fk) begin
      @(negedge clk_sys_i);
      if (is_k(lane_char[9:0], C_K28_7)) n7++;
      if (is_k(lane_char[9:0], C_K28_3)) n3++;
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic test_modes();
    for (int m = 0; m < 4; m++) begin
      do_reset(m[1:0], m[1]);
      bring_up();
      $display("test modes: mode %0d done", m);
    end
  endtask

  task automatic test_data();
    int acc;
    int n7;
    int n3;
    acc = 0;
    do_reset(2'h0, 1'b0);
    @(posedge clk_sys_i);
    sample <= 16'h1234;
    sample_valid <= 1'b1;
    repeat (10) begin
      @(negedge clk_sys_i);
      if (sample_ready === 1'b1) acc++;
    end
    check(acc, 4);
    check(sample_ready, 0);
    bring_up();
    repeat (2 * fk) @(negedge clk_sys_i);
    count_align(n7, n3);
    check(n7 + n3, fk);
    check(n3, 1);
    @(posedge clk_sys_i);
    alt <= 1'b1;
    repeat (8) @(negedge clk_sys_i);
    count_align(n7, n3);
    check(n7 + n3, 0);
    @(posedge clk_sys_i);
    link_req <= 1'b0;
    repeat (8) @(negedge clk_sys_i);
    check(is_k(lane_char[9:0], C_K28_5), 1);
    check(link_up, 0);
    bring_up();
    $display("test data: done");
  endtask

  task automatic test_scr();
    int n7;
    int n3;
    do_reset(2'h0, 1'b1);
    @(posedge clk_sys_i);
    sample <= 16'h1234;
    sample_valid <= 1'b1;
    bring_up();
    repeat (2 * fk) @(negedge clk_sys_i);
    count_align(n7, n3);
    // constant data would give a full multiframe of alignment chars unscrambled
    check(n7 + n3 < 8, 1);
    $display("test scrambled: done");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    // the whole run needs well under this many cycles
    repeat (30000) @(posedge clk_sys_i);
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    summarize();
  end

  initial begin
    test_modes();
    test_data();
    test_scr();
    summarize();
  end
endmodule
